// ===== logic/rls_pkg.sv
// Constants and types for the reset level sequencer
`default_nettype none
package rls_pkg;
  // Bus and config space shape
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NL = 6;          // Four data links, two control links
  localparam int DVW = 4;
  // Link rate after hardware reset
  localparam int CLK_HZ = 40_000_000;
  localparam int LINK_HZ = 10_000_000;
  localparam logic [DVW-1:0] LINK_DIV_RST = DVW'(CLK_HZ / LINK_HZ);
  // Cache: [0] plain RAM mode, [15:8] capacity in Kbytes (16)
  localparam logic [DW-1:0] CACHE_RST = 32'h0000_1001;
  // Workspace descriptor meaning "no process"
  localparam logic [DW-1:0] NO_PROCESS_VALUE = 32'h8000_0000;
  // Identify answer, value arbitrary
  localparam logic [DW-1:0] DEVICE_ID = 32'h0000_5A01;
  localparam logic [DW-1:0] BOOT_STEP = 32'h0000_0004;
  // Config space word offsets
  localparam logic [AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AW-1:0] OFS_CTRL = 8'h04;
  localparam logic [AW-1:0] OFS_ID_HDR = 8'h08;
  localparam logic [AW-1:0] OFS_RET_HDR = 8'h0C;
  localparam logic [AW-1:0] OFS_MI_CFG = 8'h10;
  localparam logic [AW-1:0] OFS_VCP_CFG = 8'h14;
  localparam logic [AW-1:0] OFS_CACHE = 8'h18;
  localparam logic [AW-1:0] OFS_START = 8'h1C;
  localparam logic [AW-1:0] OFS_LINK0 = 8'h20;
  // Link config fields
  localparam int LF_DIV = 0;
  localparam int LF_SINGLE = 4;
  localparam int LF_HALT = 5;
  localparam int LF_RUN = 6;
  // Control register bits
  localparam int CB_STANDALONE = 0;
  localparam int CB_RUN = 1;
  localparam int CB_RESTART = 2;
  // Status register bits
  localparam int SB_LEVEL = 0;
  localparam int SB_ROM = 2;
  localparam int SB_HDR = 3;
  localparam int SB_MI = 4;
  localparam int SB_VCP = 5;
  localparam int SB_RUN = 6;
  localparam int SB_RESTART = 7;
  typedef enum logic [1:0] {LVL0, LVL1, LVL2, LVL3} rls_level_t;
  typedef enum logic [3:0] {
    CMD_START, CMD_RESET, CMD_IDENTIFY, CMD_STOP, CMD_CFG_RD, CMD_CFG_WR,
    CMD_RUN, CMD_BOOT, CMD_BOOT_DATA, CMD_REBOOT
  } rls_cmd_t;
endpackage : rls_pkg
`default_nettype wire

// ===== logic/rls_reset_level_sequencer.sv
// Reset level sequencer with configuration space and command handling
//
// The implementer's own choices: the register addresses and strobed register access.
`default_nettype none
module rls_reset_level_sequencer
  import rls_pkg::*;
(
  // Clock and reset pins
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              rom_start_pin,
  // Configuration bus
  input  wire logic [AW-1:0]     reg_addr,
  input  wire logic [DW-1:0]     reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DW-1:0]     reg_rdata,
  // Upstream control link commands
  input  wire logic              cmd_valid,
  input  wire logic [3:0]        cmd_code,
  input  wire logic [DW-1:0]     cmd_addr,
  input  wire logic [DW-1:0]     cmd_data,
  input  wire logic              link_err,
  // Responses
  output logic                   rsp_valid,
  output logic      [3:0]        rsp_code,
  output logic      [DW-1:0]     rsp_data,
  output logic                   rsp_ok,
  output logic                   err_msg,
  // Recovery
  output logic                   bank5_en,
  output logic                   rom_restart,
  // Processor
  output logic                   proc_run,
  output logic      [DW-1:0]     wdesc,
  output logic                   sched_clear,
  // Subsystem configuration
  output logic                   mi_active,
  output logic      [DW-1:0]     mi_cfg,
  output logic                   vcp_active,
  output logic      [DW-1:0]     vcp_cfg,
  output logic      [DW-1:0]     cache_cfg,
  output logic      [NL*DVW-1:0] link_div,
  output logic      [NL-1:0]     link_single,
  output logic      [NL-1:0]     link_halt,
  output logic      [NL-1:0]     link_run,
  // Boot writes
  output logic                   boot_wr,
  output logic      [DW-1:0]     boot_addr,
  output logic      [DW-1:0]     boot_data,
  // State
  output logic      [1:0]        level,
  output logic                   rom_start
);
  rls_level_t      level_q;
  rls_cmd_t        cmd;
  logic            rs1_q, rs2_q, rst_d1_q, rom_start_q;
  logic            hdr_valid_q, standalone_q, restart_q;
  logic [DW-1:0]   id_hdr_q, ret_hdr_q, mi_cfg_q, vcp_cfg_q, cache_q, start_q;
  logic            mi_act_q, vcp_act_q, run_q, sched_clr_q;
  logic [DW-1:0]   wdesc_q, rdata_q;
  logic [6:0]      lcfg_q [NL];
  logic [NL-1:0]   lhit;
  logic            rsp_v_q, rsp_ok_q, err_q, bank_q, rrst_q;
  logic [3:0]      rsp_c_q;
  logic [DW-1:0]   rsp_d_q;
  logic            bwr_q;
  logic [DW-1:0]   baddr_q, bdata_q, bptr_q, bleft_q;
  logic            wr_en, cmd_ok_addr;
  logic [AW-1:0]   wr_a;
  logic [DW-1:0]   wr_v;
  logic            is_reset, clr1, clr0, run_go;
  logic [1:0]      rst_lvl;

  assign cmd = rls_cmd_t'(cmd_code);
  assign is_reset = cmd_valid && cmd == CMD_RESET;
  assign rst_lvl = cmd_data[1:0];
  assign clr0 = is_reset && rst_lvl == 2'd0;
  assign clr1 = is_reset && rst_lvl <= 2'd1;

  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a < OFS_LINK0 + AW'(4 * NL));
  endfunction : addr_ok

  function automatic logic [DW-1:0] rd_val(input logic [AW-1:0] a);
    rd_val = '0;
    case (a)
      OFS_STATUS: rd_val = DW'({restart_q, run_q, vcp_act_q, mi_act_q, hdr_valid_q, rom_start_q, level_q});
      OFS_CTRL:   rd_val = DW'({restart_q, 1'b0, standalone_q});
      OFS_ID_HDR:  rd_val = id_hdr_q;
      OFS_RET_HDR: rd_val = ret_hdr_q;
      OFS_MI_CFG:  rd_val = mi_cfg_q;
      OFS_VCP_CFG: rd_val = vcp_cfg_q;
      OFS_CACHE:   rd_val = cache_q;
      OFS_START:   rd_val = start_q;
      default: begin
        for (int i = 0; i < NL; i++) begin
          if (a == OFS_LINK0 + AW'(4 * i)) rd_val = DW'(lcfg_q[i]);
        end
      end
    endcase
  endfunction : rd_val

  // Link commands and bus share one write port; the link wins a collision
  always_comb begin
    wr_en = reg_wr;
    wr_a = reg_addr;
    wr_v = reg_wdata;
    if (cmd_valid && cmd == CMD_CFG_WR) begin
      wr_en = cmd_ok_addr;
      wr_a = cmd_addr[AW-1:0];
      wr_v = cmd_data;
    end
  end
  assign cmd_ok_addr = cmd_addr[DW-1:AW] == '0 && addr_ok(cmd_addr[AW-1:0]);
  assign run_go = (cmd_valid && cmd == CMD_RUN && level_q >= LVL2)
               || (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CB_RUN]);

  // Strap synchroniser and capture at reset release
  always_ff @(posedge clk) begin
    rs1_q <= rom_start_pin;
    rs2_q <= rs1_q;
    rst_d1_q <= sys_rst;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) rom_start_q <= 1'b0;
    else if (rst_d1_q) rom_start_q <= rs2_q;
  end

  // Level indicator
  always_ff @(posedge clk) begin
    if (sys_rst) level_q <= LVL0;
    else if (is_reset) begin
      if (rls_level_t'(rst_lvl) < level_q) level_q <= rls_level_t'(rst_lvl);
    end else if (level_q == LVL0 && (standalone_q || (cmd_valid && cmd == CMD_START))) level_q <= LVL1;
    else if (level_q == LVL1 && mi_act_q && vcp_act_q) level_q <= LVL2;
    else if (level_q == LVL2 && run_go) level_q <= LVL3;
  end

  // Headers survive a level 1 reset; stand-alone leaves them undefined
  always_ff @(posedge clk) begin
    if (sys_rst || clr0) begin
      hdr_valid_q <= 1'b0;
      id_hdr_q <= '0;
      ret_hdr_q <= '0;
    end else if (cmd_valid && cmd == CMD_START && !standalone_q) begin
      hdr_valid_q <= 1'b1;
      id_hdr_q <= cmd_addr;
      ret_hdr_q <= cmd_data;
    end else if (wr_en && wr_a == OFS_ID_HDR) id_hdr_q <= wr_v;
    else if (wr_en && wr_a == OFS_RET_HDR) ret_hdr_q <= wr_v;
  end

  // Subsystem configuration, cleared by hardware or level 0 or 1 reset
  always_ff @(posedge clk) begin
    if (sys_rst || clr1) begin
      mi_act_q <= 1'b0;
      vcp_act_q <= 1'b0;
      mi_cfg_q <= '0;
      vcp_cfg_q <= '0;
      cache_q <= CACHE_RST;
      start_q <= '0;
      standalone_q <= 1'b0;
    end else if (wr_en) begin
      case (wr_a)
        OFS_MI_CFG: begin
          mi_cfg_q <= wr_v;
          mi_act_q <= 1'b1;
        end
        OFS_VCP_CFG: begin
          vcp_cfg_q <= wr_v;
          vcp_act_q <= 1'b1;
        end
        OFS_CACHE: cache_q <= wr_v;
        OFS_START: start_q <= wr_v;
        OFS_CTRL: standalone_q <= wr_v[CB_STANDALONE];
        default: ;
      endcase
    end
  end

  // Identical field set for every data and control link
  generate
    for (genvar i = 0; i < NL; i++) begin : g_link
      assign lhit[i] = wr_en && wr_a == OFS_LINK0 + AW'(4 * i);
      always_ff @(posedge clk) begin
        if (sys_rst || clr1) begin
          lcfg_q[i] <= '0;
          lcfg_q[i][LF_DIV +: DVW] <= LINK_DIV_RST;
          lcfg_q[i][LF_SINGLE] <= 1'b1;
        end else if (lhit[i]) lcfg_q[i] <= wr_v[6:0];
      end
      assign link_div[i*DVW +: DVW] = lcfg_q[i][LF_DIV +: DVW];
      assign link_single[i] = lcfg_q[i][LF_SINGLE];
      assign link_halt[i] = lcfg_q[i][LF_HALT];
      assign link_run[i] = lcfg_q[i][LF_RUN];
    end
  endgenerate

  // Processor; any reset level stops the application
  always_ff @(posedge clk) begin
    sched_clr_q <= sys_rst || is_reset;
    if (sys_rst || is_reset) begin
      run_q <= 1'b0;
      wdesc_q <= NO_PROCESS_VALUE;
    end else if (cmd_valid && cmd == CMD_STOP) run_q <= 1'b0;
    else if (run_go) begin
      run_q <= 1'b1;
      wdesc_q <= cmd_valid && cmd == CMD_RUN ? cmd_data : start_q;
    end
  end

  // Stand-alone recovery; a new restart beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
      bank_q <= 1'b0;
      rrst_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      err_q <= link_err && !standalone_q;
      rrst_q <= (link_err && standalone_q) || (cmd_valid && cmd == CMD_REBOOT);
      if ((link_err && standalone_q) || (cmd_valid && cmd == CMD_REBOOT)) bank_q <= 1'b1;
      if (link_err && standalone_q) restart_q <= 1'b1;
      else if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CB_RESTART]) restart_q <= 1'b0;
    end
  end

  // Boot loader: one payload command writes one word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bwr_q <= 1'b0;
      baddr_q <= '0;
      bdata_q <= '0;
      bptr_q <= '0;
      bleft_q <= '0;
    end else begin
      bwr_q <= 1'b0;
      if (cmd_valid && cmd == CMD_BOOT) begin
        bptr_q <= cmd_addr;
        bleft_q <= cmd_data;
      end else if (cmd_valid && cmd == CMD_BOOT_DATA && bleft_q != '0) begin
        bwr_q <= 1'b1;
        baddr_q <= bptr_q;
        bdata_q <= cmd_data;
        bptr_q <= bptr_q + BOOT_STEP;
        bleft_q <= bleft_q > BOOT_STEP ? bleft_q - BOOT_STEP : '0;
      end
    end
  end

  // Bus read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) rdata_q <= '0;
    else if (reg_rd) rdata_q <= rd_val(reg_addr);
    else rdata_q <= '0;
  end

  // One response per command, next cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_v_q <= 1'b0;
      rsp_c_q <= '0;
      rsp_d_q <= '0;
      rsp_ok_q <= 1'b0;
    end else begin
      rsp_v_q <= cmd_valid;
      rsp_c_q <= cmd_code;
      rsp_d_q <= '0;
      rsp_ok_q <= 1'b1;
      case (cmd)
        CMD_IDENTIFY: rsp_d_q <= DEVICE_ID;
        CMD_CFG_RD: begin
          rsp_d_q <= cmd_ok_addr ? rd_val(cmd_addr[AW-1:0]) : '0;
          rsp_ok_q <= cmd_ok_addr;
        end
        CMD_CFG_WR: rsp_ok_q <= cmd_ok_addr;
        CMD_RUN: rsp_ok_q <= level_q >= LVL2;
        CMD_BOOT_DATA: rsp_ok_q <= bleft_q != '0;
        CMD_START: rsp_ok_q <= !standalone_q;
        default: ;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign rsp_valid = rsp_v_q;
  assign rsp_code = rsp_c_q;
  assign rsp_data = rsp_d_q;
  assign rsp_ok = rsp_ok_q;
  assign err_msg = err_q;
  assign bank5_en = bank_q;
  assign rom_restart = rrst_q;
  assign proc_run = run_q;
  assign wdesc = wdesc_q;
  assign sched_clear = sched_clr_q;
  assign mi_active = mi_act_q;
  assign mi_cfg = mi_cfg_q;
  assign vcp_active = vcp_act_q;
  assign vcp_cfg = vcp_cfg_q;
  assign cache_cfg = cache_q;
  assign boot_wr = bwr_q;
  assign boot_addr = baddr_q;
  assign boot_data = bdata_q;
  assign level = level_q;
  assign rom_start = rom_start_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_hw_reset_state: assert property ($fell(sys_rst) |-> level_q == LVL0 && !run_q
    && wdesc_q == NO_PROCESS_VALUE && sched_clr_q) else $error("reset state wrong");
  chk_link_defaults: assert property ($fell(sys_rst) |-> link_single == '1
    && link_halt == '0 && link_run == '0 && link_div[DVW-1:0] == LINK_DIV_RST) else $error("link defaults wrong");
  chk_cache_default: assert property ($fell(sys_rst) |-> cache_q == CACHE_RST && !mi_act_q)
    else $error("cache default wrong");
  chk_start_labels: assert property (cmd_valid && cmd == CMD_START && level_q == LVL0 && !standalone_q
    |=> level_q == LVL1 && hdr_valid_q) else $error("start did not label");
  chk_reset_one_keeps: assert property (is_reset && rst_lvl == 2'd1 && level_q != LVL0
    |=> hdr_valid_q == $past(hdr_valid_q) && !mi_act_q && level_q == LVL1) else $error("level 1 reset wrong");
  chk_reset_two_keeps: assert property (is_reset && rst_lvl == 2'd2 && level_q == LVL3
    |=> mi_cfg_q == $past(mi_cfg_q) && !run_q && level_q == LVL2) else $error("level 2 reset wrong");
  chk_standalone_err: assert property (link_err && standalone_q
    |=> rrst_q && bank_q && !err_q ##1 (!rrst_q || $past(link_err) || $past(cmd_valid)))
    else $error("stand-alone recovery wrong");
  chk_rsp_timing: assert property (cmd_valid |=> rsp_v_q && rsp_c_q == $past(cmd_code))
    else $error("response missing");
  chk_inactive_zero: assert property (!mi_act_q |-> mi_cfg_q == '0 && (vcp_act_q || vcp_cfg_q == '0))
    else $error("inactive config not cleared");
endmodule : rls_reset_level_sequencer
`default_nettype wire

// ===== verif/rls_ctrl_model.sv
// Control process model driving the upstream control link
`default_nettype none
module rls_ctrl_model
  import rls_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Commands and link events
  output var  logic          cmd_valid,
  output var  logic [3:0]    cmd_code,
  output var  logic [DW-1:0] cmd_addr,
  output var  logic [DW-1:0] cmd_data,
  output var  logic          link_err,
  // Responses
  input  wire logic          rsp_valid,
  input  wire logic [3:0]    rsp_code,
  input  wire logic [DW-1:0] rsp_data,
  input  wire logic          rsp_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_addr  = 32'h0000_0000;
    cmd_data  = 32'h0000_0000;
    link_err  = 1'b0;
  end
  // One command, held to the taking edge, answer sampled in the next cycle
  // Start, reset level, boot and config writes all pass here
  task automatic send(input rls_cmd_t c, input logic [DW-1:0] a, input logic [DW-1:0] d,
                      output logic ok, output logic [DW-1:0] rd, output logic echo);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_addr  <= a;
    cmd_data  <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Released lines show the inverse, never the stale value
    cmd_code  <= ~c;
    cmd_addr  <= ~a;
    cmd_data  <= ~d;
    #1;
    ok   = rsp_ok;
    rd   = rsp_data;
    echo = rsp_valid & (rsp_code === 4'(c));
  endtask : send
  task automatic raise_err();
    @(posedge clk);
    link_err <= 1'b1;
    @(posedge clk);
    link_err <= 1'b0;
    #1;
  endtask : raise_err
endmodule : rls_ctrl_model
`default_nettype wire

// ===== verif/rls_reset_level_sequencer_test.sv
// Self-checking bench for the reset level sequencer
`default_nettype none
module rls_reset_level_sequencer_test
  import rls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              sys_rst, rom_start_pin, reg_wr, reg_rd;
  logic [AW-1:0]     reg_addr;
  logic [DW-1:0]     reg_wdata, reg_rdata, cmd_addr, cmd_data, rsp_data, wdesc, mi_cfg, vcp_cfg, cache_cfg;
  logic [DW-1:0]     boot_addr, boot_data, rv;
  logic [3:0]        cmd_code, rsp_code;
  logic              cmd_valid, link_err, rsp_valid, rsp_ok, err_msg, bank5_en, rom_restart, proc_run;
  logic              sched_clear, mi_active, vcp_active, boot_wr, rom_start, ok, echo;
  logic [NL*DVW-1:0] link_div;
  logic [NL-1:0]     link_single, link_halt, link_run;
  logic [1:0]        level;
  int                failures, cmp_count;
  localparam logic [DW-1:0] ID = 32'h0000_0A05, RET = 32'h0000_0B06, MIV = 32'h0000_1234, VCV = 32'h0000_5678;

  rls_reset_level_sequencer rls_reset_level_sequencer_inst (
    .clk(clk), .sys_rst(sys_rst), .rom_start_pin(rom_start_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .link_err(link_err), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data),
    .rsp_ok(rsp_ok), .err_msg(err_msg), .bank5_en(bank5_en), .rom_restart(rom_restart),
    .proc_run(proc_run), .wdesc(wdesc), .sched_clear(sched_clear), .mi_active(mi_active),
    .mi_cfg(mi_cfg), .vcp_active(vcp_active), .vcp_cfg(vcp_cfg), .cache_cfg(cache_cfg),
    .link_div(link_div), .link_single(link_single), .link_halt(link_halt), .link_run(link_run),
    .boot_wr(boot_wr), .boot_addr(boot_addr), .boot_data(boot_data), .level(level), .rom_start(rom_start));
  rls_ctrl_model rls_ctrl_model_inst (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .link_err(link_err), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_data(rsp_data), .rsp_ok(rsp_ok));

  always #12.5 clk = ~clk;

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic cmd(input rls_cmd_t c, input logic [DW-1:0] a, input logic [DW-1:0] d);
    rls_ctrl_model_inst.send(c, a, d, ok, rv, echo);
    check(echo, 1'b1);
  endtask : cmd
  task automatic t_reset(input logic pin);
    @(posedge clk);
    sys_rst       <= 1'b1;
    rom_start_pin <= pin;
    repeat (8) @(posedge clk);
    #1;
    check(sched_clear, 1'b1);
    check(proc_run, 1'b0);
    check(wdesc, NO_PROCESS_VALUE);
    check({mi_active, vcp_active}, 2'b00);
    check(cache_cfg, CACHE_RST);
    for (int i = 0; i < NL; i++) check(link_div[i*DVW +: DVW], LINK_DIV_RST);
    check({link_single, link_halt, link_run}, {{NL{1'b1}}, {2*NL{1'b0}}});
    check({level, bank5_en}, 3'b000);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(rom_start, pin);
    rd(OFS_STATUS, rv);
    check({rv[SB_ROM], rv[SB_HDR]}, {pin, 1'b0});
    $display("test reset done");
  endtask : t_reset
  task automatic t_start();
    cmd(CMD_START, ID, RET);
    check(level, LVL1);
    rd(OFS_ID_HDR, rv);
    check(rv, ID);
    rd(OFS_RET_HDR, rv);
    check(rv, RET);
    cmd(CMD_IDENTIFY, 32'h0, 32'h0);
    check(rv, DEVICE_ID);
    $display("test start done");
  endtask : t_start
  task automatic t_config();
    cmd(CMD_RUN, 32'h0, 32'h0);
    check({ok, proc_run}, 2'b00);
    cmd(CMD_CFG_WR, 32'(OFS_MI_CFG), MIV);
    check({ok, level}, {1'b1, LVL1});
    cmd(CMD_CFG_WR, 32'(OFS_VCP_CFG), VCV);
    check({mi_active, vcp_active, vcp_cfg}, {2'b11, VCV});
    // Level follows the active flags one cycle later
    @(posedge clk);
    #1;
    check(level, LVL2);
    check(mi_cfg, MIV);
    cmd(CMD_CFG_RD, 32'(OFS_VCP_CFG), 32'h0);
    check({ok, rv}, {1'b1, VCV});
    cmd(CMD_CFG_RD, 32'h0000_0003, 32'h0);
    check(ok, 1'b0);
    wr(8'h30, 32'h0000_0042);
    wr(OFS_LINK0, 32'h0000_0042);
    #1;
    check({link_div[4*DVW +: DVW], link_single[4], link_run[4]}, {4'h2, 2'b01});
    check({link_div[DVW-1:0], link_single[0], link_run[0]}, {4'h2, 2'b01});
    rd(8'hFC, rv);
    check(rv, 32'h0);
    $display("test config done");
  endtask : t_config
  task automatic t_boot();
    cmd(CMD_BOOT, 32'h0000_0100, 32'h0000_0008);
    check(ok, 1'b1);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_BOOT_DATA, 32'h0, 32'h0000_AB00 + i);
      check({ok, boot_wr}, (i < 2) ? 2'b11 : 2'b00);
      if (i < 2) check({boot_addr, boot_data}, {32'h0000_0100 + 4 * i, 32'h0000_AB00 + i});
    end
    cmd(CMD_RUN, 32'h0, 32'h0000_0200);
    check({ok, level, proc_run}, {1'b1, LVL3, 1'b1});
    check(wdesc, 32'h0000_0200);
    cmd(CMD_STOP, 32'h0, 32'h0);
    check(proc_run, 1'b0);
    // Register path run takes the start register as descriptor
    wr(OFS_START, 32'h0000_0300);
    wr(OFS_CTRL, 32'h0000_0002);
    #1;
    check({proc_run, wdesc}, {1'b1, 32'h0000_0300});
    $display("test boot done");
  endtask : t_boot
  task automatic t_levels();
    cmd(CMD_RESET, 32'h0, 32'h0000_0002);
    check({level, proc_run, sched_clear}, {LVL2, 2'b01});
    check({mi_cfg, mi_active}, {MIV, 1'b1});
    cmd(CMD_RESET, 32'h0, 32'h0000_0001);
    check({level, mi_active, mi_cfg}, {LVL1, 1'b0, 32'h0});
    check(link_div[4*DVW +: DVW], LINK_DIV_RST);
    rd(OFS_ID_HDR, rv);
    check(rv, ID);
    cmd(CMD_RESET, 32'h0, 32'h0);
    check(level, LVL0);
    rd(OFS_STATUS, rv);
    check({rv[SB_HDR], rv[SB_LEVEL +: 2]}, 3'b000);
    $display("test levels done");
  endtask : t_levels
  task automatic t_errors();
    rls_ctrl_model_inst.raise_err();
    check({err_msg, rom_restart, bank5_en}, 3'b100);
    wr(OFS_CTRL, 32'h0000_0001);
    rls_ctrl_model_inst.raise_err();
    check({err_msg, rom_restart, bank5_en, level}, {3'b011, LVL1});
    rd(OFS_STATUS, rv);
    check(rv[SB_RESTART], 1'b1);
    cmd(CMD_START, ID, RET);
    check(ok, 1'b0);
    cmd(CMD_REBOOT, 32'h0, 32'h0);
    check({rom_restart, bank5_en}, 2'b11);
    wr(OFS_CTRL, 32'h0000_0005);
    rd(OFS_STATUS, rv);
    check({rv[SB_RESTART], rv[SB_LEVEL +: 2]}, {1'b0, LVL1});
    $display("test errors done");
  endtask : t_errors

  initial begin
    {sys_rst, rom_start_pin, reg_wr, reg_rd} = 4'b1000;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    t_reset(1'b0);
    t_start();
    t_config();
    t_boot();
    t_levels();
    t_errors();
    // Mid-run hardware reset, strap now high
    t_reset(1'b1);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("ERROR %0t run did not finish", $time);
    wrap_up();
  end
endmodule : rls_reset_level_sequencer_test
`default_nettype wire
